// *** hw/ssp_fifo.sv ***
module ssp_fifo
    import ssp_pkg::*;
#(
    parameter int WIDTH = WORD_W,
    parameter int DEPTH = FIFO_DEPTH,
    localparam int AW   = $clog2(DEPTH)
)(
    input  wire logic             core_clk,
    input  wire logic             arst_n,
    input  wire logic             flush,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData,
    output logic      [AW:0]      count
);
    localparam logic [AW:0]   FULL_COUNT = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST_INDEX = AW'(DEPTH - 1);

    logic [WIDTH-1:0] store_q [DEPTH];
    logic [AW-1:0]    wrPtr_q;
    logic [AW-1:0]    rdPtr_q;
    logic [AW:0]      count_q;
    logic             push;
    logic             pop;

    // a full FIFO refuses the word; the source sees inReady low
    assign inReady  = (count_q != FULL_COUNT);
    assign outValid = (count_q != '0);
    assign outData  = store_q[rdPtr_q];
    assign count    = count_q;
    assign push     = inValid && inReady && !flush;
    assign pop      = outValid && outReady && !flush;

    genvar e;
    generate
        for (e = 0; e < DEPTH; e++) begin : g_entry
            always_ff @(posedge core_clk or negedge arst_n)
            begin
                if (!arst_n)
                    store_q[e] <= '0;
                else if (push && wrPtr_q == AW'(e))
                    store_q[e] <= inData;
            end
        end
    endgenerate

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end else if (flush) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end else begin
            if (push)
                wrPtr_q <= (wrPtr_q == LAST_INDEX) ? '0 : wrPtr_q + 1'b1;
            if (pop)
                rdPtr_q <= (rdPtr_q == LAST_INDEX) ? '0 : rdPtr_q + 1'b1;
            if (push && !pop)
                count_q <= count_q + 1'b1;
            else if (pop && !push)
                count_q <= count_q - 1'b1;
        end
    end

endmodule : ssp_fifo

// *** hw/ssp_pkg.sv ***
package ssp_pkg;

    // register map on the processor's I/O space
    localparam logic [15:0] ADDR_DATA_PORT = 16'hFFF0;
    localparam logic [15:0] ADDR_CONTROL   = 16'hFFF1;

    localparam int          WORD_W         = 16;
    localparam int          FIFO_DEPTH     = 4;
    localparam logic [15:0] CONTROL_RESET  = 16'h0000;
    localparam logic [15:0] RDATA_NONE     = 16'h0000;

    // interrupt trigger selections
    localparam logic [1:0]  TRIG_SEL_1     = 2'h0;
    localparam logic [1:0]  TRIG_SEL_2     = 2'h1;
    localparam logic [1:0]  TRIG_SEL_3     = 2'h2;

    // control/status word, bit 15 first
    typedef struct packed {
        logic       haltFree;
        logic       haltSoft;
        logic       txPendingFlag;
        logic       rxNonemptyFlag;
        logic [1:0] txTriggerSel;
        logic [1:0] rxTriggerSel;
        logic       rxOverrunFlag;
        logic       rxClockPinLevel;
        logic       txSectionRun;
        logic       rxSectionRun;
        logic       txSyncInternal;
        logic       txClockInternal;
        logic       perWordSyncMode;
        logic       loopbackEnable;
    } ssp_ctrl_type;

    // one I/O cycle from the processor
    typedef struct packed {
        logic        wrStrobe;
        logic        rdStrobe;
        logic [15:0] addr;
        logic [15:0] wrData;
    } ssp_io_req_type;

    typedef enum logic [1:0] {TX_IDLE, TX_SYNC, TX_SHIFT} ssp_tx_state_type;
    typedef enum logic       {RX_IDLE, RX_SHIFT}          ssp_rx_state_type;

endpackage : ssp_pkg

// *** hw/ssp_port.sv ***
// Notes on behaviour
// - one data port: write pushes transmit FIFO, read pops receive FIFO
// - empty transmit shifter loads the oldest transmit FIFO word
// - transmit shifter sends each word most significant bit first
// - receive shifter gathers bits msb first, full word goes to FIFO
// - transmit service request follows the selected transmit trigger
// - receive service request follows the selected receive trigger
// - halt bits: stop now, stop after word, or keep running
// - pending flag set by a write, cleared once transmit FIFO is empty and shifter idle
// - non-empty flag shows receive FIFO holds any word
// - transmit trigger: room for one, two, three words, or empty
// - receive trigger: one, two, three words held, or full
// - word arriving at full receive FIFO is dropped, sets overrun
// - bit 6 shows live level of the receive clock pin
// - section run bits low hold transmitter or receiver stopped
// - external sync mode: sync pin is input, transmitter waits
// - internal sync mode: device drives sync pulse per run, or per word in per-word mode
// - internal clock mode drives transmit clock at half core rate
// - continuous mode needs one sync; per-word mode needs one each
// - loopback routes transmit data and sync into the receiver
// - loopback with internal clock also clocks the receiver
// - writes to a full transmit FIFO are discarded
// - each new data bit leaves on a transmit clock rising edge
module ssp_port
    import ssp_pkg::*;
(
    input  wire logic           core_clk,
    input  wire logic           arst_n,
    input  wire ssp_io_req_type ioReq,
    output logic [15:0]         ioRdData,
    input  wire logic           emuHalt,
    input  wire logic           txClkPinIn,
    output logic                txClkPinOut,
    output logic                txClkPinOe_n,
    input  wire logic           txSyncPinIn,
    output logic                txSyncPinOut,
    output logic                txSyncPinOe_n,
    output logic                serialOutPin,
    input  wire logic           rxClkPin,
    input  wire logic           rxSyncPin,
    input  wire logic           serialInPin,
    output logic                txServiceIrq,
    output logic                rxServiceIrq
);
    localparam int          CW       = $clog2(FIFO_DEPTH) + 1;
    localparam logic [CW-1:0] FULL_CNT = CW'(FIFO_DEPTH);
    localparam logic [3:0]  LAST_BIT = 4'(WORD_W - 1);

    ssp_ctrl_type     ctrl_q;
    ssp_ctrl_type     status;
    ssp_tx_state_type txState_q;
    ssp_rx_state_type rxState_q;

    // pin synchronisers, first stage read only by the second
    logic [1:0]  txClkSync_q, txSyncSync_q, rxClkSync_q;
    logic [1:0]  rxSyncSync_q, serialInSync_q;

    logic        txClkInt_q, txLvlPrev_q, rxLvlPrev_q;
    logic        txSync_q, serialOut_q, extSyncSeen_q;
    logic [15:0] txShift_q, rxShift_q, rdData_q, rxPushData_q;
    logic [3:0]  txBitCnt_q, rxBitCnt_q;
    logic        rxPushValid_q, txPending_q, rxOverrun_q;
    logic        txIrq_q, rxIrq_q, txClkOe_n_q, txSyncOe_n_q;

    logic        wrData, wrCtrl, rdData, rdCtrl;
    logic        txFifoInReady, txFifoValid, rxFifoInReady, rxFifoValid;
    logic [15:0] txFifoData, rxFifoData;
    logic [CW-1:0] txCount, rxCount;
    logic        txHalt, rxHalt, txActive, rxActive;
    logic        txLvl, txRise, txFall, rxLvl, rxFall;
    logic        txSyncLvl, rxSyncLvl, rxDataLvl;
    logic        txLoad, txWordDone, txLoadNext;

    assign wrData = ioReq.wrStrobe && ioReq.addr == ADDR_DATA_PORT;
    assign wrCtrl = ioReq.wrStrobe && ioReq.addr == ADDR_CONTROL;
    assign rdData = ioReq.rdStrobe && ioReq.addr == ADDR_DATA_PORT;
    assign rdCtrl = ioReq.rdStrobe && ioReq.addr == ADDR_CONTROL;

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n) begin
            txClkSync_q    <= '0;
            txSyncSync_q   <= '0;
            rxClkSync_q    <= '0;
            rxSyncSync_q   <= '0;
            serialInSync_q <= '0;
        end else begin
            txClkSync_q    <= {txClkSync_q[0], txClkPinIn};
            txSyncSync_q   <= {txSyncSync_q[0], txSyncPinIn};
            rxClkSync_q    <= {rxClkSync_q[0], rxClkPin};
            rxSyncSync_q   <= {rxSyncSync_q[0], rxSyncPin};
            serialInSync_q <= {serialInSync_q[0], serialInPin};
        end
    end

    // control register: read-only flag bits are stored here too, status replaces them
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            ctrl_q <= ssp_ctrl_type'(CONTROL_RESET);
        else if (wrCtrl)
            ctrl_q <= ssp_ctrl_type'(ioReq.wrData);
    end

    always_comb
    begin
        status                 = ctrl_q;
        status.txPendingFlag   = txPending_q;
        status.rxNonemptyFlag  = rxFifoValid;
        status.rxOverrunFlag   = rxOverrun_q;
        status.rxClockPinLevel = rxClkSync_q[1];
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            rdData_q <= RDATA_NONE;
        else if (rdData)
            rdData_q <= rxFifoValid ? rxFifoData : RDATA_NONE;
        else if (rdCtrl)
            rdData_q <= status;
    end
    assign ioRdData = rdData_q;

    // halt: "stop after word" waits until the shifter state machine is back in its idle state
    assign txHalt = emuHalt && !ctrl_q.haltFree
                 && (!ctrl_q.haltSoft || txState_q == TX_IDLE);
    assign rxHalt = emuHalt && !ctrl_q.haltFree
                 && (!ctrl_q.haltSoft || rxState_q == RX_IDLE);
    assign txActive = ctrl_q.txSectionRun && !txHalt;
    assign rxActive = ctrl_q.rxSectionRun && !rxHalt;

    ssp_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .flush    (!ctrl_q.txSectionRun),
        .inValid  (wrData),
        .inReady  (txFifoInReady),
        .inData   (ioReq.wrData),
        .outValid (txFifoValid),
        .outReady (txLoad),
        .outData  (txFifoData),
        .count    (txCount)
    );

    ssp_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .flush    (!ctrl_q.rxSectionRun),
        .inValid  (rxPushValid_q),
        .inReady  (rxFifoInReady),
        .inData   (rxPushData_q),
        .outValid (rxFifoValid),
        .outReady (rdData),
        .outData  (rxFifoData),
        .count    (rxCount)
    );

    // internal bit clock: one toggle per core cycle gives half the rate
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            txClkInt_q <= 1'b0;
        else if (!ctrl_q.txSectionRun || !ctrl_q.txClockInternal)
            txClkInt_q <= 1'b0;
        else if (txActive)
            txClkInt_q <= !txClkInt_q;
    end

    assign txLvl  = ctrl_q.txClockInternal ? txClkInt_q : txClkSync_q[1];
    assign rxLvl  = (ctrl_q.loopbackEnable && ctrl_q.txClockInternal)
                  ? txClkInt_q : rxClkSync_q[1];
    assign txRise = txLvl && !txLvlPrev_q && txActive;
    assign txFall = !txLvl && txLvlPrev_q && txActive;
    assign rxFall = !rxLvl && rxLvlPrev_q && rxActive;

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n) begin
            txLvlPrev_q <= 1'b0;
            rxLvlPrev_q <= 1'b0;
        end else begin
            txLvlPrev_q <= txLvl;
            rxLvlPrev_q <= rxLvl;
        end
    end

    assign txSyncLvl = ctrl_q.txSyncInternal ? txSync_q : txSyncSync_q[1];
    assign rxSyncLvl = ctrl_q.loopbackEnable
                     ? txSyncLvl : rxSyncSync_q[1];
    assign rxDataLvl = ctrl_q.loopbackEnable
                     ? serialOut_q : serialInSync_q[1];

    // external sync is caught on a falling edge, used on the next rise
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            extSyncSeen_q <= 1'b0;
        else if (!ctrl_q.txSectionRun || ctrl_q.txSyncInternal)
            extSyncSeen_q <= 1'b0;
        else if (txFall && txSyncSync_q[1])
            extSyncSeen_q <= 1'b1;
        else if (txRise && txState_q != TX_SHIFT)
            extSyncSeen_q <= 1'b0;
        else if (txRise && txWordDone)
            extSyncSeen_q <= 1'b0;
    end

    assign txWordDone = txState_q == TX_SHIFT && txBitCnt_q == LAST_BIT;
    // after a word: continuous mode runs on, per-word mode needs a sync
    assign txLoadNext = txFifoValid && (!ctrl_q.perWordSyncMode
                     || (ctrl_q.txSyncInternal ? txSync_q
                                               : extSyncSeen_q));

    always_comb
    begin
        txLoad = 1'b0;
        if (txRise) begin
            case (txState_q)
                TX_IDLE:  txLoad = !ctrl_q.txSyncInternal
                                && extSyncSeen_q && txFifoValid;
                TX_SYNC:  txLoad = txFifoValid;
                TX_SHIFT: txLoad = txWordDone && txLoadNext;
                default:  txLoad = 1'b0;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n) begin
            txState_q   <= TX_IDLE;
            txShift_q   <= '0;
            txBitCnt_q  <= '0;
            serialOut_q <= 1'b0;
            txSync_q    <= 1'b0;
        end else if (!ctrl_q.txSectionRun) begin
            txState_q   <= TX_IDLE;
            txShift_q   <= '0;
            txBitCnt_q  <= '0;
            serialOut_q <= 1'b0;
            txSync_q    <= 1'b0;
        end else if (txLoad) begin
            txState_q   <= TX_SHIFT;
            txShift_q   <= txFifoData;
            serialOut_q <= txFifoData[WORD_W-1];
            txBitCnt_q  <= '0;
            txSync_q    <= 1'b0;
        end else if (txRise) begin
            case (txState_q)
                TX_IDLE:
                begin
                    if (ctrl_q.txSyncInternal && txFifoValid) begin
                        txSync_q  <= 1'b1;
                        txState_q <= TX_SYNC;
                    end
                end
                TX_SYNC:
                begin
                    txSync_q  <= 1'b0;
                    txState_q <= TX_IDLE;
                end
                TX_SHIFT:
                begin
                    if (txWordDone) begin
                        txState_q <= TX_IDLE;
                        txSync_q  <= 1'b0;
                    end else begin
                        txShift_q   <= {txShift_q[WORD_W-2:0], 1'b0};
                        serialOut_q <= txShift_q[WORD_W-2];
                        txBitCnt_q  <= txBitCnt_q + 4'h1;
                        // next word's sync rides alongside the last bit
                        if (txBitCnt_q == LAST_BIT - 4'h1
                            && ctrl_q.txSyncInternal
                            && ctrl_q.perWordSyncMode
                            && txCount != '0)
                            txSync_q <= 1'b1;
                    end
                end
                default: txState_q <= TX_IDLE;
            endcase
        end
    end

    // receiver samples on falling edges of its bit clock
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n) begin
            rxState_q     <= RX_IDLE;
            rxShift_q     <= '0;
            rxBitCnt_q    <= '0;
            rxPushValid_q <= 1'b0;
            rxPushData_q  <= '0;
        end else if (!ctrl_q.rxSectionRun) begin
            rxState_q     <= RX_IDLE;
            rxShift_q     <= '0;
            rxBitCnt_q    <= '0;
            rxPushValid_q <= 1'b0;
        end else begin
            rxPushValid_q <= 1'b0;
            if (rxFall) begin
                case (rxState_q)
                    RX_IDLE:
                    begin
                        if (rxSyncLvl) begin
                            rxState_q  <= RX_SHIFT;
                            rxBitCnt_q <= '0;
                        end
                    end
                    RX_SHIFT:
                    begin
                        rxShift_q  <= {rxShift_q[WORD_W-2:0], rxDataLvl};
                        rxBitCnt_q <= rxBitCnt_q + 4'h1;
                        if (rxBitCnt_q == LAST_BIT) begin
                            rxPushValid_q <= 1'b1;
                            rxPushData_q  <= {rxShift_q[WORD_W-2:0],
                                              rxDataLvl};
                            rxBitCnt_q    <= '0;
                            if (ctrl_q.perWordSyncMode && !rxSyncLvl)
                                rxState_q <= RX_IDLE;
                        end
                    end
                    default: rxState_q <= RX_IDLE;
                endcase
            end
        end
    end

    // status flags: a setting event beats a drain or read clear in the same cycle, a section stop beats both
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n) begin
            txPending_q <= 1'b0;
            rxOverrun_q <= 1'b0;
        end else begin
            if (!ctrl_q.txSectionRun)
                txPending_q <= 1'b0;
            else if (wrData && txFifoInReady)
                txPending_q <= 1'b1;
            else if (!txFifoValid && txState_q == TX_IDLE)
                txPending_q <= 1'b0;
            if (!ctrl_q.rxSectionRun)
                rxOverrun_q <= 1'b0;
            else if (rxPushValid_q && !rxFifoInReady)
                rxOverrun_q <= 1'b1;
            else if (rdData)
                rxOverrun_q <= 1'b0;
        end
    end

    // service requests are levels; the processor's flag logic latches them
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n) begin
            txIrq_q <= 1'b0;
            rxIrq_q <= 1'b0;
        end else begin
            case (ctrl_q.txTriggerSel)
                TRIG_SEL_1: txIrq_q <= txCount <= FULL_CNT - CW'(1);
                TRIG_SEL_2: txIrq_q <= txCount <= FULL_CNT - CW'(2);
                TRIG_SEL_3: txIrq_q <= txCount <= FULL_CNT - CW'(3);
                default:    txIrq_q <= txCount == '0;
            endcase
            case (ctrl_q.rxTriggerSel)
                TRIG_SEL_1: rxIrq_q <= rxCount >= CW'(1);
                TRIG_SEL_2: rxIrq_q <= rxCount >= CW'(2);
                TRIG_SEL_3: rxIrq_q <= rxCount >= CW'(3);
                default:    rxIrq_q <= rxCount == FULL_CNT;
            endcase
            if (!ctrl_q.txSectionRun)
                txIrq_q <= 1'b0;
            if (!ctrl_q.rxSectionRun)
                rxIrq_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n) begin
            txClkOe_n_q  <= 1'b1;
            txSyncOe_n_q <= 1'b1;
        end else begin
            txClkOe_n_q  <= !ctrl_q.txClockInternal;
            txSyncOe_n_q <= !ctrl_q.txSyncInternal;
        end
    end

    assign txClkPinOut   = txClkInt_q;
    assign txClkPinOe_n  = txClkOe_n_q;
    assign txSyncPinOut  = txSync_q;
    assign txSyncPinOe_n = txSyncOe_n_q;
    assign serialOutPin  = serialOut_q;
    assign txServiceIrq  = txIrq_q;
    assign rxServiceIrq  = rxIrq_q;

endmodule : ssp_port

// *** tb/ssp_codec_model.sv ***
module ssp_codec_model
#(
    parameter int HALF_NS = 200
)(
    output logic rxClkPin,
    output logic rxSyncPin,
    output logic serialInPin,
    input  logic serialOutPin
);
    timeunit 1ns;
    timeprecision 1ns;
    // what the codec heard on its data input during the last frame
    logic [15:0] heard;
    initial
    begin
        heard       = '0;
        rxClkPin    = 1'b0;
        rxSyncPin   = 1'b0;
        serialInPin = 1'b0;
    end
    // clock stands still between frames; a sync clock only opens a run
    task automatic send(input logic [15:0] w, input logic sync);
        for (int i = sync ? 0 : 1; i <= 16; i++)
        begin
            rxClkPin    <= 1'b1;
            rxSyncPin   <= (i == 0);
            serialInPin <= (i == 0) ? ~serialInPin : w[16 - i];
            #HALF_NS;
            if (i > 0)
                heard = {heard[14:0], serialOutPin};
            rxClkPin <= 1'b0;
            #HALF_NS;
        end
        rxSyncPin   <= 1'b0;
        serialInPin <= ~serialInPin; // no stale bit after the frame
    endtask : send
endmodule : ssp_codec_model

// *** tb/ssp_port_properties.sv ***
module ssp_port_properties
    import ssp_pkg::*;
(
    input wire logic           core_clk,
    input wire logic           arst_n,
    input wire logic           emuHalt,
    input wire ssp_io_req_type ioReq,
    input wire logic [15:0]    ioRdData,
    input wire logic           txClkPinOut,
    input wire logic           txClkPinOe_n,
    input wire logic           txSyncPinOut,
    input wire logic           txSyncPinOe_n,
    input wire logic           txServiceIrq,
    input wire logic           rxServiceIrq
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] ctlQ;
    logic        ctlWr;
    logic        ctlRd;
    logic        dataWr;
    assign ctlWr  = ioReq.wrStrobe && ioReq.addr == ADDR_CONTROL;
    assign ctlRd  = ioReq.rdStrobe && ioReq.addr == ADDR_CONTROL;
    assign dataWr = ioReq.wrStrobe && ioReq.addr == ADDR_DATA_PORT;
    // shadow of control; status bits in it are never compared
    always_ff @(posedge core_clk or negedge arst_n)
        if (!arst_n)
            ctlQ <= CONTROL_RESET;
        else if (ctlWr)
            ctlQ <= ioReq.wrData;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    clk_oe_follow_a: assert property (
        ctlWr |-> ##2 txClkPinOe_n == !$past(ioReq.wrData[2], 2))
        else $error("clock pin enable wrong");
    sync_oe_follow_a: assert property (
        ctlWr |-> ##2 txSyncPinOe_n == !$past(ioReq.wrData[3], 2))
        else $error("sync pin enable wrong");
    tx_held_quiet_a: assert property (
        !ctlQ[5] [*3] |-> !txServiceIrq)
        else $error("tx request while held");
    rx_held_quiet_a: assert property (
        !ctlQ[4] [*3] |-> !rxServiceIrq)
        else $error("rx request while held");
    int_clock_run_a: assert property (
        (ctlQ[2] && ctlQ[5] && (ctlQ[15] || !emuHalt)) [*3]
        |-> txClkPinOut != $past(txClkPinOut))
        else $error("internal clock not at half rate");
    sync_pulse_width_a: assert property (
        $rose(txSyncPinOut) && ctlQ[2] |-> txSyncPinOut ##2 !txSyncPinOut)
        else $error("sync pulse not one bit wide");
    read_back_a: assert property (
        ctlRd |=> ioRdData[15:14] == $past(ctlQ[15:14])
            && ioRdData[11:8] == $past(ctlQ[11:8])
            && ioRdData[5:0] == $past(ctlQ[5:0]))
        else $error("control read back wrong");
    pending_set_a: assert property (
        dataWr && ctlQ[5] ##[1:4] ctlRd |=> ioRdData[13])
        else $error("pending flag not set");
    cover property ($rose(txSyncPinOut));
    cover property ($rose(rxServiceIrq));
    cover property (ctlRd ##1 ioRdData[7]);
endmodule : ssp_port_properties

bind ssp_port ssp_port_properties u_ssp_port_properties (
    .core_clk, .arst_n, .emuHalt, .ioReq, .ioRdData, .txClkPinOut,
    .txClkPinOe_n,
    .txSyncPinOut, .txSyncPinOe_n, .txServiceIrq, .rxServiceIrq);

// *** tb/test_framed_sync_serial_port.sv ***
module test_framed_sync_serial_port
    import ssp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic           core_clk, arst_n, txClkPinOut, txClkPinOe_n;
    logic           txSyncPinOut, txSyncPinOe_n, serialOutPin;
    logic           rxClkPin, rxSyncPin, serialInPin;
    logic           txServiceIrq, rxServiceIrq, emuHalt;
    ssp_io_req_type ioReq;
    logic [15:0]    ioRdData;
    int             fails, nChecks;

    ssp_port u_ssp_port (.core_clk, .arst_n, .ioReq, .ioRdData, .emuHalt,
        .txClkPinIn(rxClkPin), .txClkPinOut, .txClkPinOe_n,
        .txSyncPinIn(rxSyncPin), .txSyncPinOut, .txSyncPinOe_n,
        .serialOutPin, .rxClkPin, .rxSyncPin, .serialInPin, .txServiceIrq,
        .rxServiceIrq);
    ssp_codec_model u_ssp_codec_model (.rxClkPin, .rxSyncPin, .serialInPin,
        .serialOutPin);

    task automatic chk(input string what, input logic [15:0] exp, got);
        nChecks++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value %s exp %h got %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [15:0] a, d);
        @(posedge core_clk);
        ioReq <= '{1'b1, 1'b0, a, d};
        @(posedge core_clk);
        ioReq.wrStrobe <= 1'b0;
    endtask : wr

    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        @(posedge core_clk);
        ioReq <= '{1'b0, 1'b1, a, 16'h0000};
        @(posedge core_clk);
        ioReq.rdStrobe <= 1'b0;
        @(posedge core_clk);
        #1;
        d = ioRdData;
    endtask : rd

    task automatic test_done();
        $display("checks %0d mismatches %0d", nChecks, fails);
        if (fails == 0 && nChecks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : test_done

    task automatic test_rx();
        logic [15:0] v;
        logic [15:0] w [5] = '{16'hA5C3, 16'h0001, 16'h8000, 16'h7E18,
                               16'hFFFF};
        rd(ADDR_CONTROL, v);
        chk("control reset", 16'h0000, v);
        wr(ADDR_CONTROL, 16'h0100);
        wr(ADDR_CONTROL, 16'h0130);
        wr(ADDR_DATA_PORT, 16'h6D29);
        for (int i = 0; i < 5; i++)
        begin
            u_ssp_codec_model.send(w[i], i == 0);
            repeat (10) @(posedge core_clk);
            #1;
            if (i == 0)
                chk("tx word", 16'h6D29, u_ssp_codec_model.heard);
            chk("rx request", {15'h0, (i > 0)}, {15'h0, rxServiceIrq});
        end
        chk("tx request", 16'h0001, {15'h0, txServiceIrq});
        rd(ADDR_CONTROL, v);
        chk("status full", 16'h11B0, v);
        for (int i = 0; i < 4; i++)
        begin
            rd(ADDR_DATA_PORT, v);
            chk("rx word", w[i], v);
        end
        rd(ADDR_CONTROL, v);
        chk("status empty", 16'h0130, v);
        rd(ADDR_DATA_PORT, v);
        chk("empty read", 16'h0000, v);
        $display("rx test done");
    endtask : test_rx

    task automatic test_loop();
        logic [15:0] v;
        wr(ADDR_CONTROL, 16'h0C0F);
        wr(ADDR_CONTROL, 16'h0C3F);
        wr(ADDR_DATA_PORT, 16'hA5C3);
        wr(ADDR_DATA_PORT, 16'h3C96);
        rd(ADDR_CONTROL, v);
        chk("pending", 16'h2C3F, v);
        chk("pin drive", 16'h0000, {14'h0, txClkPinOe_n, txSyncPinOe_n});
        for (int n = 0; n < 300 && v[13] === 1'b1; n++)
            rd(ADDR_CONTROL, v);
        chk("drained", 16'h0000, {15'h0, v[13]});
        repeat (20) @(posedge core_clk);
        #1;
        chk("tx empty request", 16'h0001, {15'h0, txServiceIrq});
        rd(ADDR_DATA_PORT, v);
        chk("loop word 1", 16'hA5C3, v);
        rd(ADDR_DATA_PORT, v);
        chk("loop word 2", 16'h3C96, v);
        $display("loop test done");
    endtask : test_loop

    task automatic test_halt();
        logic a, b;
        @(posedge core_clk);
        emuHalt <= 1'b1;
        repeat (3) @(posedge core_clk);
        #1;
        a = txClkPinOut;
        @(posedge core_clk);
        #1;
        b = txClkPinOut;
        chk("halted clock", 16'h0000, {15'h0, a ^ b});
        wr(ADDR_CONTROL, 16'h8C3F);
        @(posedge core_clk);
        #1;
        a = txClkPinOut;
        @(posedge core_clk);
        #1;
        b = txClkPinOut;
        chk("free clock", 16'h0001, {15'h0, a ^ b});
        emuHalt <= 1'b0;
        $display("halt test done");
    endtask : test_halt

    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    initial
    begin
        #500000;
        fails++;
        test_done();
    end

    initial
    begin
        arst_n = 1'b0;
        ioReq  = '0;
        emuHalt = 1'b0;
        repeat (12) @(posedge core_clk);
        arst_n <= 1'b1;
        test_rx();
        test_loop();
        test_halt();
        test_done();
    end
endmodule : test_framed_sync_serial_port
